/* File: plc_terminal_model.sv */
// physical input terminals, each flipped once per request
// assumes toggle is driven right after rising clock edges
`timescale 1ns/1ns
module plc_terminal_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] toggle,
    output logic input_terminal_zero,
    output logic input_terminal_one
);
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            {input_terminal_one, input_terminal_zero} <= 2'h0;
        else
            {input_terminal_one, input_terminal_zero} <=
                {input_terminal_one, input_terminal_zero} ^ toggle;
endmodule : plc_terminal_model

/* File: plc_timer_counter_unit.sv */
// on-delay timers, program-driven counters and two hardware pulse counters
// assumes all inputs synchronous to clk; program drives enables, presets, clears
//
// Operation
// - timers 0-47 step 100 ms; 46,47 retentive
// - timers 48-63 step 10 ms; 62,63 retentive
// - preset counts steps; delay is preset times step
// - count while enabled; contact at preset
// - general timer disabled: contact off, count zero
// - preset immediate or from data register
// - timer starts counting at the next step tick
// - retentive timers hold count, resume later
// - counters add one per rising input
// - counter at setpoint closes, ignores pulses
// - active clear holds counter zero, open
// - hardware counters follow physical input terminals
// - config zero: plain inputs, no hardware counting
// - configs 1-3 route input zero, edge select
// - configs 4-5 route input one, edge select
// - configs 6-10 route both, given edges
// - clearing init flag applies routing, flag rises
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns

module plc_timer_counter_unit #(
    parameter int unsigned slow_step_cycles = plc_timer_pkg::SLOW_STEP_CYCLES,
    parameter int unsigned fast_step_cycles = plc_timer_pkg::FAST_STEP_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire plc_timer_pkg::reg_req_t reg_req,
    output logic [plc_timer_pkg::DATA_W-1:0] rdata,
    input wire logic [plc_timer_pkg::TIMER_NUM-1:0] timer_enable,
    input wire logic [plc_timer_pkg::TIMER_NUM-1:0] timer_clear,
    input wire plc_timer_pkg::preset_write_t preset_write,
    input wire logic [plc_timer_pkg::VALUE_W-1:0] data_register_value,
    input wire logic [plc_timer_pkg::COUNTER_NUM-1:0] count_input,
    input wire logic [plc_timer_pkg::COUNTER_NUM-1:0] count_clear,
    input wire logic input_terminal_zero,
    input wire logic input_terminal_one,
    input wire logic [1:0] hw_clear,
    output logic discrete_input_zero,
    output logic discrete_input_one,
    output logic [plc_timer_pkg::TIMER_NUM-1:0] timer_contact,
    output logic [plc_timer_pkg::COUNTER_NUM-1:0] counter_contact,
    output logic [plc_timer_pkg::HW_W-1:0] hw_pulse_counter_zero,
    output logic [plc_timer_pkg::HW_W-1:0] hw_pulse_counter_one,
    output logic peripheral_init_flag
);
    import plc_timer_pkg::*;

    state_t state;
    state_t next_state;

    // edge routing of the two terminals per configuration value
    function automatic route_t decode_route(input logic [DATA_W-1:0] cfg);
        route_t r;
        r = '0;
        case (cfg)
            16'h0001: r.zero = '{rise: 1'b1, fall: 1'b0};
            16'h0002: r.zero = '{rise: 1'b0, fall: 1'b1};
            16'h0003: r.zero = '{rise: 1'b1, fall: 1'b1};
            16'h0004: r.one = '{rise: 1'b1, fall: 1'b0};
            16'h0005: r.one = '{rise: 1'b0, fall: 1'b1};
            16'h0006:
            begin
                r.zero = '{rise: 1'b1, fall: 1'b0};
                r.one = '{rise: 1'b1, fall: 1'b0};
            end
            16'h0007:
            begin
                r.zero = '{rise: 1'b0, fall: 1'b1};
                r.one = '{rise: 1'b1, fall: 1'b0};
            end
            16'h0008:
            begin
                r.zero = '{rise: 1'b1, fall: 1'b1};
                r.one = '{rise: 1'b1, fall: 1'b0};
            end
            16'h0009:
            begin
                r.zero = '{rise: 1'b1, fall: 1'b0};
                r.one = '{rise: 1'b0, fall: 1'b1};
            end
            16'h000a:
            begin
                r.zero = '{rise: 1'b0, fall: 1'b1};
                r.one = '{rise: 1'b0, fall: 1'b1};
            end
            default: r = '0;
        endcase
        return r;
    endfunction : decode_route

    // edge of a terminal counted under the given selection
    function automatic logic edge_hit(input edge_sel_t sel, input logic now, input logic prev);
        return (sel.rise && now && !prev) || (sel.fall && !now && prev);
    endfunction : edge_hit

    function automatic logic is_retentive(input int i);
        return i == RET_SLOW_A || i == RET_SLOW_B || i == RET_FAST_A || i == RET_FAST_B;
    endfunction : is_retentive

    logic slow_tick;
    logic fast_tick;
    logic step;
    logic [VALUE_W-1:0] preset_value;
    logic [VALUE_W-1:0] cnt;

    assign slow_tick = state.slow_div == DIV_W'(slow_step_cycles - 1);
    assign fast_tick = state.fast_div == DIV_W'(fast_step_cycles - 1);
    // indirect preset taken from the data register value
    assign preset_value = preset_write.indirect ? data_register_value : preset_write.constant;

    always_comb
    begin
        next_state = state;
        step = 1'b0;
        cnt = '0;

        next_state.slow_div = slow_tick ? '0 : state.slow_div + 1'b1;
        next_state.fast_div = fast_tick ? '0 : state.fast_div + 1'b1;

        // preset and setpoint loads from the program
        if (preset_write.valid)
        begin
            if (preset_write.is_counter)
                next_state.counter_setpoint[preset_write.index] = preset_value;
            else
                next_state.timer_preset[preset_write.index] = preset_value;
        end

        for (int i = 0; i < TIMER_NUM; i++)
        begin
            step = (i < SLOW_TIMER_NUM) ? slow_tick : fast_tick;
            cnt = state.timer_count[i];
            if (timer_clear[i])
            begin
                cnt = '0;
            end
            else if (timer_enable[i])
            begin
                // counting starts on the first step tick after enabling
                if (step && cnt < next_state.timer_preset[i])
                    cnt = cnt + 1'b1;
            end
            else if (!is_retentive(i))
            begin
                cnt = '0;
            end
            next_state.timer_count[i] = cnt;
            if (timer_clear[i])
                next_state.timer_done[i] = 1'b0;
            else if (timer_enable[i])
                next_state.timer_done[i] = cnt >= next_state.timer_preset[i];
            else if (is_retentive(i))
                // disabled retentive contact keeps its state, so a never-run one stays open
                next_state.timer_done[i] = state.timer_done[i];
            else
                next_state.timer_done[i] = 1'b0;
        end

        next_state.count_input_prev = count_input;
        for (int i = 0; i < COUNTER_NUM; i++)
        begin
            cnt = state.counter_value[i];
            if (count_clear[i])
                cnt = '0;
            else if (count_input[i] && !state.count_input_prev[i] && !state.counter_done[i])
                cnt = cnt + 1'b1;
            next_state.counter_value[i] = cnt;
            next_state.counter_done[i] = !count_clear[i]
                && (state.counter_done[i] || cnt >= next_state.counter_setpoint[i]);
        end

        // hardware counters see the raw terminals, never a program signal
        next_state.terminal_zero_prev = input_terminal_zero;
        next_state.terminal_one_prev = input_terminal_one;
        if (hw_clear[0])
            next_state.hw_count_zero = '0;
        else if (edge_hit(state.route.zero, input_terminal_zero, state.terminal_zero_prev))
            next_state.hw_count_zero = state.hw_count_zero + 1'b1;
        if (hw_clear[1])
            next_state.hw_count_one = '0;
        else if (edge_hit(state.route.one, input_terminal_one, state.terminal_one_prev))
            next_state.hw_count_one = state.hw_count_one + 1'b1;

        // reinitialisation applies the stored routing and raises the flag
        if (state.init_pending)
        begin
            next_state.route = decode_route(state.edge_cfg);
            next_state.hw_count_zero = '0;
            next_state.hw_count_one = '0;
            next_state.init_flag = 1'b1;
            next_state.init_pending = 1'b0;
        end

        // register port
        if (reg_req.write)
        begin
            case (reg_req.addr)
                REG_EDGE_CFG: next_state.edge_cfg = reg_req.wdata;
                REG_INIT_FLAG:
                begin
                    if (!reg_req.wdata[0])
                    begin
                        next_state.init_flag = 1'b0;
                        next_state.init_pending = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        next_state.rdata = '0;
        if (reg_req.read)
        begin
            case (reg_req.addr)
                REG_EDGE_CFG: next_state.rdata = state.edge_cfg;
                REG_INIT_FLAG: next_state.rdata = {{(DATA_W-1){1'b0}}, state.init_flag};
                REG_HW0_LO: next_state.rdata = state.hw_count_zero[DATA_W-1:0];
                REG_HW0_HI: next_state.rdata = state.hw_count_zero[HW_W-1:DATA_W];
                REG_HW1_LO: next_state.rdata = state.hw_count_one[DATA_W-1:0];
                REG_HW1_HI: next_state.rdata = state.hw_count_one[HW_W-1:DATA_W];
                default: next_state.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= '0;
            state.edge_cfg <= EDGE_CFG_RESET;
            state.init_pending <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign timer_contact = state.timer_done;
    assign counter_contact = state.counter_done;
    assign hw_pulse_counter_zero = state.hw_count_zero;
    assign hw_pulse_counter_one = state.hw_count_one;
    assign peripheral_init_flag = state.init_flag;
    // a routed terminal no longer reads as a discrete input
    assign discrete_input_zero = input_terminal_zero
        && !(state.route.zero.rise || state.route.zero.fall);
    assign discrete_input_one = input_terminal_one
        && !(state.route.one.rise || state.route.one.fall);

endmodule : plc_timer_counter_unit

/* File: plc_timer_counter_unit_checker.sv */
// port assertions for the timer/counter unit
// assumes it is bound onto plc_timer_counter_unit
`timescale 1ns/1ns
module plc_timer_counter_unit_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire plc_timer_pkg::reg_req_t reg_req,
    input wire logic [plc_timer_pkg::DATA_W-1:0] rdata,
    input wire logic [plc_timer_pkg::TIMER_NUM-1:0] timer_enable,
    input wire logic [plc_timer_pkg::TIMER_NUM-1:0] timer_clear,
    input wire logic [plc_timer_pkg::COUNTER_NUM-1:0] count_clear,
    input wire logic input_terminal_zero,
    input wire logic input_terminal_one,
    input wire logic discrete_input_zero,
    input wire logic discrete_input_one,
    input wire logic [plc_timer_pkg::TIMER_NUM-1:0] timer_contact,
    input wire logic [plc_timer_pkg::COUNTER_NUM-1:0] counter_contact,
    input wire logic [plc_timer_pkg::HW_W-1:0] hw_pulse_counter_zero,
    input wire logic peripheral_init_flag
);
    import plc_timer_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence reinit_req;
        reg_req.write && reg_req.addr == REG_INIT_FLAG && !reg_req.wdata[0];
    endsequence
    sequence flag_read;
        reg_req.read && reg_req.addr == REG_INIT_FLAG;
    endsequence
    AST_REINIT: assert property (reinit_req |=> !peripheral_init_flag ##1 peripheral_init_flag)
        else $error("init flag sequence wrong");
    AST_FLAG_READ: assert property (flag_read |=> rdata == {15'h0, $past(peripheral_init_flag)})
        else $error("init flag read wrong");
    AST_GEN_OFF: assert property (!timer_enable[0] |=> !timer_contact[0])
        else $error("general timer contact stays on");
    AST_CONTACT_CAUSE: assert property ($rose(timer_contact[0]) |-> $past(timer_enable[0]))
        else $error("timer contact without enable");
    AST_RET_HOLD: assert property (timer_contact[46] && !timer_clear[46] |=> timer_contact[46])
        else $error("retentive contact lost");
    AST_CNT_HOLD: assert property (counter_contact[0] && !count_clear[0] |=> counter_contact[0])
        else $error("counter contact lost");
    AST_CNT_CLEAR: assert property (count_clear[0] [*2] |-> !counter_contact[0])
        else $error("counter contact during clear");
    AST_HW_CAUSE: assert property ($changed(hw_pulse_counter_zero) && hw_pulse_counter_zero != 0
        |-> $past(input_terminal_zero) != $past(input_terminal_zero, 2))
        else $error("hw count without terminal edge");
    AST_GATE: assert property ((discrete_input_zero <= input_terminal_zero)
        && (discrete_input_one <= input_terminal_one))
        else $error("discrete input not from terminal");
endmodule : plc_timer_counter_unit_checker

bind plc_timer_counter_unit plc_timer_counter_unit_checker i_checker (.*);

/* File: plc_timer_pkg.sv */
// constants, register map and carrier types of the timer/counter unit
// assumes a single 250 MHz system clock and a 16-bit register port
package plc_timer_pkg;

    localparam int TIMER_NUM = 64;
    localparam int SLOW_TIMER_NUM = 48;
    localparam int COUNTER_NUM = 64;
    localparam int VALUE_W = 16;
    localparam int HW_W = 32;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int DIV_W = 32;

    // retentive timer numbers
    localparam int RET_SLOW_A = 46;
    localparam int RET_SLOW_B = 47;
    localparam int RET_FAST_A = 62;
    localparam int RET_FAST_B = 63;

    // time steps
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int NS_PER_MS = 1000000;
    localparam int SLOW_STEP_MS = 100;
    localparam int FAST_STEP_MS = 10;
    localparam int SLOW_STEP_CYCLES = SLOW_STEP_MS * NS_PER_MS / CLOCK_PERIOD_NS;
    localparam int FAST_STEP_CYCLES = FAST_STEP_MS * NS_PER_MS / CLOCK_PERIOD_NS;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_EDGE_CFG = 4'h0;
    localparam logic [ADDR_W-1:0] REG_INIT_FLAG = 4'h1;
    localparam logic [ADDR_W-1:0] REG_HW0_LO = 4'h2;
    localparam logic [ADDR_W-1:0] REG_HW0_HI = 4'h3;
    localparam logic [ADDR_W-1:0] REG_HW1_LO = 4'h4;
    localparam logic [ADDR_W-1:0] REG_HW1_HI = 4'h5;

    // reset values and limits
    localparam logic [DATA_W-1:0] EDGE_CFG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CFG_LAST = 16'h000a;

    typedef struct packed {
        logic rise;
        logic fall;
    } edge_sel_t;

    typedef struct packed {
        edge_sel_t zero;
        edge_sel_t one;
    } route_t;

    // program-side preset load: one cycle pulse in valid
    typedef struct packed {
        logic valid;
        logic is_counter;
        logic [5:0] index;
        logic indirect;
        logic [VALUE_W-1:0] constant;
    } preset_write_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } reg_req_t;

    typedef struct packed {
        logic [DIV_W-1:0] slow_div;
        logic [DIV_W-1:0] fast_div;
        logic [TIMER_NUM-1:0][VALUE_W-1:0] timer_count;
        logic [TIMER_NUM-1:0][VALUE_W-1:0] timer_preset;
        logic [TIMER_NUM-1:0] timer_done;
        logic [COUNTER_NUM-1:0][VALUE_W-1:0] counter_value;
        logic [COUNTER_NUM-1:0][VALUE_W-1:0] counter_setpoint;
        logic [COUNTER_NUM-1:0] counter_done;
        logic [COUNTER_NUM-1:0] count_input_prev;
        logic [HW_W-1:0] hw_count_zero;
        logic [HW_W-1:0] hw_count_one;
        logic terminal_zero_prev;
        logic terminal_one_prev;
        logic [DATA_W-1:0] edge_cfg;
        route_t route;
        logic init_flag;
        logic init_pending;
        logic [DATA_W-1:0] rdata;
    } state_t;

endpackage : plc_timer_pkg

/* File: test_plc_timer_counter_unit.sv */
// self-checking bench of the timer/counter unit
// assumes short step parameters for simulation
`timescale 1ns/1ns
module test_plc_timer_counter_unit;
    import plc_timer_pkg::*;
    localparam int slow = 10;
    localparam int fast = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t reg_req = '0;
    preset_write_t preset_write = '0;
    logic [TIMER_NUM-1:0] timer_enable = '0, timer_clear = '0;
    logic [COUNTER_NUM-1:0] count_input = '0, count_clear = '0;
    logic [VALUE_W-1:0] data_register_value = '0;
    logic [1:0] toggle = '0, hw_clear = '0;
    logic term0, term1, disc0, disc1, flag;
    logic [DATA_W-1:0] rdata;
    logic [TIMER_NUM-1:0] timer_contact;
    logic [COUNTER_NUM-1:0] counter_contact;
    logic [HW_W-1:0] hw0, hw1;
    int n_fail = 0, n_checks = 0;
    logic [31:0] seed = 32'hf613f9da;
    logic [3:0] sel_tab [0:10] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'h2, 4'h1, 4'ha, 4'h6, 4'he, 4'h9, 4'h5};
    always #2 clk = ~clk;
    plc_terminal_model i_terms (.clk(clk), .rst_n(rst_n), .toggle(toggle),
        .input_terminal_zero(term0), .input_terminal_one(term1));
    plc_timer_counter_unit #(.slow_step_cycles(slow), .fast_step_cycles(fast)) i_dut (
        .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .rdata(rdata),
        .timer_enable(timer_enable), .timer_clear(timer_clear), .preset_write(preset_write),
        .data_register_value(data_register_value), .count_input(count_input),
        .count_clear(count_clear), .input_terminal_zero(term0), .input_terminal_one(term1),
        .hw_clear(hw_clear), .discrete_input_zero(disc0), .discrete_input_one(disc1),
        .timer_contact(timer_contact), .counter_contact(counter_contact),
        .hw_pulse_counter_zero(hw0), .hw_pulse_counter_one(hw1), .peripheral_init_flag(flag));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) reg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clk) reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk) reg_req <= '{addr: a, wdata: 16'h0, write: 1'b0, read: 1'b1};
        @(posedge clk) reg_req <= '0;
        #1 chk_word("rdata", {16'h0, exp}, {16'h0, rdata});
    endtask : rd
    task automatic load(input logic c, input logic [5:0] i, input logic ind, input logic [15:0] v);
        @(posedge clk);
        data_register_value <= v;
        preset_write <= '{valid: 1'b1, is_counter: c, index: i, indirect: ind,
            constant: ind ? ~v : v};
        @(posedge clk) preset_write <= '0;
    endtask : load
    task automatic timer_run(input int t, input int lo, input int hi);
        int n;
        n = 0;
        @(posedge clk) timer_enable[t] <= 1'b1;
        while (timer_contact[t] !== 1'b1 && n < hi + 5)
        begin
            tick(1);
            n++;
        end
        chk_bit("timer delay", 1'b1, n >= lo && n <= hi);
    endtask : timer_run
    task automatic pulse(input int n, input int base, input int sp);
        for (int k = 1; k <= n; k++)
        begin
            @(posedge clk) count_input[0] <= 1'b1;
            @(posedge clk) count_input[0] <= 1'b0;
            tick(2);
            chk_bit("counter contact", base + k >= sp, counter_contact[0]);
        end
    endtask : pulse
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    initial
    begin
        tick(20000);
        n_fail++;
        final_report();
    end
    initial
    begin
        int sp, e0, e1;
        logic l0, l1;
        logic [3:0] s;
        logic [31:0] t;
        l0 = 1'b0;
        l1 = 1'b0;
        tick(20);
        rst_n <= 1'b1;
        tick(2);
        rd(REG_INIT_FLAG, 16'h1);
        rd(REG_EDGE_CFG, EDGE_CFG_RESET);
        rd(4'hf, 16'h0);
        load(1'b0, 6'd0, 1'b0, 16'd5);
        timer_run(0, 4 * slow + 1, 5 * slow + 2);
        @(posedge clk) timer_enable[0] <= 1'b0;
        tick(2);
        chk_bit("timer0 contact", 1'b0, timer_contact[0]);
        load(1'b0, 6'd48, 1'b1, 16'd3);
        timer_run(48, 2 * fast + 1, 3 * fast + 2);
        @(posedge clk) timer_enable[48] <= 1'b0;
        load(1'b0, 6'd46, 1'b0, 16'd4);
        @(posedge clk) timer_enable[46] <= 1'b1;
        tick(25);
        @(posedge clk) timer_enable[46] <= 1'b0;
        tick(40);
        chk_bit("timer46 contact", 1'b0, timer_contact[46]);
        timer_run(46, 1, 2 * slow + 2);
        @(posedge clk) timer_enable[46] <= 1'b0;
        tick(3);
        chk_bit("timer46 held", 1'b1, timer_contact[46]);
        @(posedge clk) timer_clear[46] <= 1'b1;
        tick(2);
        chk_bit("timer46 cleared", 1'b0, timer_contact[46]);
        @(posedge clk) timer_clear[46] <= 1'b0;
        sp = int'(rnd() % 4) + 2;
        load(1'b1, 6'd0, 1'b0, 16'(sp));
        // setpoint 0 after reset closed the contact; open it before counting
        @(posedge clk) count_clear[0] <= 1'b1;
        @(posedge clk) count_clear[0] <= 1'b0;
        pulse(sp + 2, 0, sp);
        @(posedge clk) count_clear[0] <= 1'b1;
        pulse(2, 0, 99);
        @(posedge clk) count_clear[0] <= 1'b0;
        pulse(sp, 0, sp);
        for (int cfg = 0; cfg <= 11; cfg++)
        begin
            wr(REG_EDGE_CFG, 16'(cfg));
            wr(REG_INIT_FLAG, 16'h0);
            #1 chk_bit("init flag low", 1'b0, flag);
            tick(3);
            chk_bit("init flag high", 1'b1, flag);
            s = cfg > 10 ? 4'h0 : sel_tab[cfg];
            e0 = 0;
            e1 = 0;
            repeat (40)
            begin
                t = rnd();
                @(posedge clk) toggle <= t[1:0];
                l0 = l0 ^ t[0];
                l1 = l1 ^ t[1];
                e0 += t[0] ? (l0 ? s[3] : s[2]) : 0;
                e1 += t[1] ? (l1 ? s[1] : s[0]) : 0;
            end
            @(posedge clk) toggle <= 2'h0;
            tick(3);
            chk_word("hw zero", 32'(e0), hw0);
            chk_word("hw one", 32'(e1), hw1);
            chk_bit("discrete zero", s[3:2] == 2'h0 && l0, disc0);
            chk_bit("discrete one", s[1:0] == 2'h0 && l1, disc1);
            rd(REG_HW0_LO, 16'(e0));
            rd(REG_HW0_HI, 16'h0);
            rd(REG_HW1_LO, 16'(e1));
            rd(REG_HW1_HI, 16'h0);
            @(posedge clk) hw_clear <= 2'h3;
            @(posedge clk) hw_clear <= 2'h0;
            tick(1);
            chk_word("hw zero cleared", 32'h0, hw0);
            chk_word("hw one cleared", 32'h0, hw1);
        end
        final_report();
    end
endmodule : test_plc_timer_counter_unit
